// ---- logic/cs_decode.sv ----
// Chip-select address and access-type decode with its register file.
// Assumes the core cycle inputs come from logic on ref_clk, held for the
// whole external bus cycle, and an AXI4-Lite master on the register port.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Individual bank bases are 16-bit read/write.
// - Banks 0,1 compare base with address 31:16.
// - Shared 8-bit base compares address 31:24.
// - Address 23:21 picks the shared-group bank.
// - Base registers are not reset.
// - Mask registers 32-bit; only valid bit resets.
// - Bank 0,1 masks give address masking; all masks give access qualifiers.
// - Mask bit one makes address bit don't-care.
// - Block size follows set mask bits; shared 2MB.
// - Set space qualifier gives plain cycle, no select.
// - Write protect blocks writes, reads still select.
// - Alternate master with qualifier clear ignores spaces.
// - Supervisor/user code/data qualifiers block their spaces.
// - CPU-space qualifier only on banks 0,1,7.
// - Banks 2-6 lack the CPU-space qualifier bit.
// - Banks 2-6 never select on CPU-space cycles.
// - No select before valid; boot bank global.
module cs_decode
  import cs_decode_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic [31:0]           coreAddr,
  input  wire logic                  cycleActive,
  input  wire logic                  cycleWrite,
  input  wire logic                  cycleSuper,
  input  wire logic                  cycleCode,
  input  wire logic                  cycleCpuSpace,
  input  wire logic                  cycleAltMaster,
  output logic [NUM_BANKS-1:0]       chipSelect_n,
  output logic                       plainCycle,
  output logic                       bootGlobal
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [15:0]          indivBase     [0:INDIV_BANKS-1];
  logic [15:0]          indivDontCare [0:INDIV_BANKS-1];
  logic [7:0]           sharedBase;
  logic [15:0]          qual          [0:NUM_BANKS-1];
  logic [NUM_BANKS-1:0] bankValid;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] decodeReg(input logic [AXI_ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[AXI_ADDR_W-1:2];
    if (a[1:0] != 2'h0) begin
      decodeReg = SEL_NONE;
    end else if (idx == IDX_BANK0_BASE) begin
      decodeReg = SEL_BANK0_BASE;
    end else if (idx == IDX_BANK1_BASE) begin
      decodeReg = SEL_BANK1_BASE;
    end else if (idx == IDX_SHARED_BASE) begin
      decodeReg = SEL_SHARED_BASE;
    end else if (idx == IDX_BANK0_MASK) begin
      decodeReg = SEL_MASK_FIRST;
    end else if (idx == IDX_BANK1_MASK) begin
      decodeReg = SEL_MASK_FIRST + 4'h1;
    end else if (idx == IDX_BANK2_QUAL) begin
      decodeReg = SEL_MASK_FIRST + 4'h2;
    end else if (idx == IDX_BANK3_QUAL) begin
      decodeReg = SEL_MASK_FIRST + 4'h3;
    end else if (idx == IDX_BANK4_QUAL) begin
      decodeReg = SEL_MASK_FIRST + 4'h4;
    end else if (idx == IDX_BANK5_QUAL) begin
      decodeReg = SEL_MASK_FIRST + 4'h5;
    end else if (idx == IDX_BANK6_QUAL) begin
      decodeReg = SEL_MASK_FIRST + 4'h6;
    end else if (idx == IDX_BANK7_QUAL) begin
      decodeReg = SEL_MASK_FIRST + 4'h7;
    end else begin
      decodeReg = SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    mergeLanes = res;
  endfunction

  // Full 32-bit view of each mask register; reserved bits read as zero.
  function automatic logic [31:0] maskView(input int bank);
    logic [15:0] hi;
    logic [15:0] impl;
    hi   = (bank < INDIV_BANKS) ? indivDontCare[bank] : 16'h0000;
    impl = (bank < INDIV_BANKS || bank == LAST_BANK) ? QUAL_IMPL_CI
                                                     : QUAL_IMPL_NO_CI;
    maskView = {hi, (qual[bank] & impl) | {15'h0000, bankValid[bank]}};
  endfunction

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  logic                  awHeld;
  logic                  wHeld;
  logic [AXI_ADDR_W-1:0] awAddrQ;
  logic [31:0]           wDataQ;
  logic [3:0]            wStrbQ;
  logic                  doWrite;
  logic [3:0]            wSel;
  logic [31:0]           wOld;
  logic [31:0]           wNew;
  logic [2:0]            wBank;

  assign awready = ~awHeld & ~bvalid;
  assign wready  = ~wHeld & ~bvalid;
  assign doWrite = clkEn & awHeld & wHeld & ~bvalid;
  assign wSel    = decodeReg(awAddrQ);
  assign wBank   = 3'(wSel - SEL_MASK_FIRST);

  always_comb begin
    wOld = 32'h0000_0000;
    if (wSel == SEL_BANK0_BASE) begin
      wOld = {16'h0000, indivBase[0]};
    end else if (wSel == SEL_BANK1_BASE) begin
      wOld = {16'h0000, indivBase[1]};
    end else if (wSel == SEL_SHARED_BASE) begin
      wOld = {24'h000000, sharedBase};
    end else if (wSel != SEL_NONE) begin
      wOld = maskView(int'(wBank));
    end
    wNew = mergeLanes(wOld, wDataQ, wStrbQ);
  end

  // Address and data are taken in either order and held until both are here.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Payload capture carries no reset; it is only read once its flag is set.
  always_ff @(posedge ref_clk) begin
    if (clkEn && awvalid && awready) begin
      awAddrQ <= awaddr;
    end
    if (clkEn && wvalid && wready) begin
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end
  end

  // ---------------------------------------------------------------------------
  // Base and mask registers
  // ---------------------------------------------------------------------------
  // Bases and mask fields hold whatever they power up with until written.
  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      if (wSel == SEL_BANK0_BASE) begin
        indivBase[0] <= wNew[15:0];
      end else if (wSel == SEL_BANK1_BASE) begin
        indivBase[1] <= wNew[15:0];
      end else if (wSel == SEL_SHARED_BASE) begin
        sharedBase <= wNew[7:0];
      end else if (wSel == SEL_MASK_FIRST) begin
        indivDontCare[0] <= wNew[31:16];
      end else if (wSel == SEL_MASK_FIRST + 4'h1) begin
        indivDontCare[1] <= wNew[31:16];
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_BANKS; g++) begin : gQual
      always_ff @(posedge ref_clk) begin
        if (doWrite && wSel != SEL_NONE && wSel >= SEL_MASK_FIRST &&
            wBank == 3'(g)) begin
          qual[g] <= wNew[15:0];
        end
      end
    end
  endgenerate

  // Only the valid flags and the boot state come out of reset defined.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bankValid  <= VALID_RESET;
      bootGlobal <= 1'b1;
    end else if (doWrite && wSel != SEL_NONE && wSel >= SEL_MASK_FIRST) begin
      bankValid[wBank] <= wNew[BIT_VALID];
      // Once the boot bank is validated only a reset brings global mode back.
      if (wBank == 3'h0 && wNew[BIT_VALID]) begin
        bootGlobal <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  logic [3:0]  rSel;
  logic [31:0] rView;

  assign arready = ~rvalid;
  assign rSel    = decodeReg(araddr);

  always_comb begin
    rView = 32'h0000_0000;
    if (rSel == SEL_BANK0_BASE) begin
      rView = {16'h0000, indivBase[0]};
    end else if (rSel == SEL_BANK1_BASE) begin
      rView = {16'h0000, indivBase[1]};
    end else if (rSel == SEL_SHARED_BASE) begin
      rView = {24'h000000, sharedBase};
    end else if (rSel != SEL_NONE) begin
      rView = maskView(int'(3'(rSel - SEL_MASK_FIRST)));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rView;
        rresp  <= (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Address compare and access qualification per bank
  // ---------------------------------------------------------------------------
  logic [NUM_BANKS-1:0] bankHit;

  generate
    for (genvar g = 0; g < NUM_BANKS; g++) begin : gBank
      logic addrHit;
      logic spaceBit;
      logic cpuBlock;
      logic blocked;

      if (g < INDIV_BANKS) begin : gIndiv
        // Each set don't-care bit doubles the 64K block.
        assign addrHit = ((coreAddr[ADDR_TOP:INDIV_LO] ^ indivBase[g]) &
                          ~indivDontCare[g]) == 16'h0000;
      end else begin : gShared
        // Bank 7 sees acknowledge cycles only with a shared base of all ones.
        assign addrHit = (coreAddr[ADDR_TOP:SHARED_LO] == sharedBase) &&
                         (coreAddr[SLOT_HI:SLOT_LO] == 3'(g));
      end

      if (g < INDIV_BANKS || g == LAST_BANK) begin : gCpuQual
        assign cpuBlock = qual[g][BIT_CI];
      end else begin : gNoCpuQual
        assign cpuBlock = 1'b1;
      end

      assign spaceBit = cycleSuper ?
                        (cycleCode ? qual[g][BIT_SC] : qual[g][BIT_SD]) :
                        (cycleCode ? qual[g][BIT_UC] : qual[g][BIT_UD]);

      assign blocked =
        (cycleWrite & qual[g][BIT_WP]) |
        (cycleAltMaster & qual[g][BIT_AM]) |
        (cycleCpuSpace ? cpuBlock :
          (~(cycleAltMaster & ~qual[g][BIT_AM]) & spaceBit));

      assign bankHit[g] = addrHit & ~blocked & bankValid[g];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Select output
  // ---------------------------------------------------------------------------
  logic [NUM_BANKS-1:0] pick;

  // Overlapping banks are the user's fault; the lowest bank wins so that
  // the pins never show two selects at once.
  always_comb begin
    if (bootGlobal) begin
      pick = NUM_BANKS'(1);
    end else begin
      pick = bankHit & NUM_BANKS'(~bankHit + NUM_BANKS'(1));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chipSelect_n <= CS_IDLE;
      plainCycle   <= 1'b0;
    end else if (clkEn) begin
      chipSelect_n <= cycleActive ? ~pick : CS_IDLE;
      plainCycle   <= cycleActive && (pick == '0);
    end
  end

endmodule // cs_decode

`default_nettype wire

// ---- logic/cs_decode_pkg.sv ----
// Constants for the chip-select address and access-type decode block.
// Assumes a 32-bit AXI4-Lite register port and a 32-bit core address.
package cs_decode_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_BANKS   = 8;
  localparam int INDIV_BANKS = 2;
  localparam int LAST_BANK   = 7;
  localparam int AXI_ADDR_W  = 12;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_BANK0_BASE  = 10'h080;
  localparam logic [9:0] IDX_BANK0_MASK  = 10'h084;
  localparam logic [9:0] IDX_BANK1_BASE  = 10'h08C;
  localparam logic [9:0] IDX_BANK1_MASK  = 10'h090;
  localparam logic [9:0] IDX_SHARED_BASE = 10'h098;
  localparam logic [9:0] IDX_BANK2_QUAL  = 10'h09C;
  localparam logic [9:0] IDX_BANK3_QUAL  = 10'h0AA;
  localparam logic [9:0] IDX_BANK4_QUAL  = 10'h0B6;
  localparam logic [9:0] IDX_BANK5_QUAL  = 10'h0C2;
  localparam logic [9:0] IDX_BANK6_QUAL  = 10'h0CE;
  localparam logic [9:0] IDX_BANK7_QUAL  = 10'h0DA;

  // Internal select codes produced by the register decode.
  localparam logic [3:0] SEL_BANK0_BASE  = 4'h0;
  localparam logic [3:0] SEL_BANK1_BASE  = 4'h1;
  localparam logic [3:0] SEL_SHARED_BASE = 4'h2;
  localparam logic [3:0] SEL_MASK_FIRST  = 4'h3;
  localparam logic [3:0] SEL_NONE        = 4'hF;

  // ---------------------------------------------------------------------------
  // Mask and qualifier fields
  // ---------------------------------------------------------------------------
  localparam int BIT_VALID = 0;
  localparam int BIT_UD    = 1;
  localparam int BIT_UC    = 2;
  localparam int BIT_SD    = 3;
  localparam int BIT_SC    = 4;
  localparam int BIT_CI    = 5;
  localparam int BIT_AM    = 6;
  localparam int BIT_WP    = 8;
  localparam logic [15:0] QUAL_IMPL_CI    = 16'h017E;
  localparam logic [15:0] QUAL_IMPL_NO_CI = 16'h015E;
  localparam logic [7:0]  VALID_RESET     = 8'h00;

  // ---------------------------------------------------------------------------
  // Core address fields
  // ---------------------------------------------------------------------------
  localparam int ADDR_TOP      = 31;
  localparam int INDIV_LO      = 16;
  localparam int SHARED_LO     = 24;
  localparam int SLOT_HI       = 23;
  localparam int SLOT_LO       = 21;

  // ---------------------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CS_IDLE     = 8'hFF;

endpackage

// ---- tb/cs_ext_memory.sv ----
// Model of the devices that sit behind the eight chip-select lines.
// Assumes active-low selects registered on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module cs_ext_memory
  import cs_decode_pkg::*;
(
  input  wire logic [NUM_BANKS-1:0] chipSelect_n,
  input  wire logic                 ref_clk,
  output logic      [3:0]           lastSel
);
  // A device answers only while its own select is low.
  // The index of the last device that answered is kept for the bench.
  // One process owns the record, so the output has a single driver.
  logic [3:0] seen = 4'hF;
  always @(posedge ref_clk) begin
    for (int k = 0; k < NUM_BANKS; k++) begin
      if (chipSelect_n[k] === 1'b0) seen <= 4'(k);
    end
  end
  assign lastSel = seen;
endmodule // cs_ext_memory
`default_nettype wire

// ---- tb/cs_decode_asserts.sv ----
// Concurrent checks on the ports of the chip-select decode block.
// Assumes one clock domain and a bind to every cs_decode instance.
`timescale 1ns/1ns
`default_nettype none
module cs_decode_asserts
  import cs_decode_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  input  wire logic                  awvalid,
  input  wire logic                  awready,
  input  wire logic                  wvalid,
  input  wire logic                  wready,
  input  wire logic                  bvalid,
  input  wire logic                  bready,
  input  wire logic                  arvalid,
  input  wire logic                  arready,
  input  wire logic                  rvalid,
  input  wire logic [31:0]           coreAddr,
  input  wire logic                  cycleActive,
  input  wire logic                  cycleCpuSpace,
  input  wire logic [NUM_BANKS-1:0]  chipSelect_n,
  input  wire logic                  plainCycle,
  input  wire logic                  bootGlobal
);
  // A frozen clock enable holds all state, so checks pause with it.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clkEn);
  sequence writeTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence readTaken;
    arvalid && arready;
  endsequence
  a_idle_deselect:
    assert property (!cycleActive |=> chipSelect_n == CS_IDLE)
      else $error("select low outside a bus cycle");
  a_single_select:
    assert property ($countones(~chipSelect_n) <= 1)
      else $error("more than one select low");
  a_plain_exact:
    assert property (cycleActive |=> plainCycle == (chipSelect_n == CS_IDLE))
      else $error("plain cycle flag disagrees with selects");
  a_boot_global:
    assert property (bootGlobal && cycleActive |=> chipSelect_n == 8'hFE)
      else $error("boot bank not selected in global mode");
  a_boot_stays_off:
    assert property (!bootGlobal |=> !bootGlobal)
      else $error("global mode came back without reset");
  a_cpu_mid_banks:
    assert property (cycleActive && cycleCpuSpace |=> &chipSelect_n[6:2])
      else $error("bank 2 to 6 selected in a CPU space cycle");
  a_slot_match:
    assert property (~chipSelect_n[7:2] != 6'h00 |->
      ~chipSelect_n[7:2] == 6'((8'h01 << $past(coreAddr[23:21])) >> 2))
      else $error("shared group select does not match slot bits");
  a_write_answer:
    assert property (writeTaken |-> ##[1:2] bvalid)
      else $error("write response late");
  a_read_answer:
    assert property (readTaken |=> rvalid)
      else $error("read data late");
  a_bvalid_clear:
    assert property (bvalid && bready |=> !bvalid)
      else $error("write response not withdrawn");
endmodule // cs_decode_asserts
bind cs_decode cs_decode_asserts chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .coreAddr(coreAddr), .cycleActive(cycleActive),
  .cycleCpuSpace(cycleCpuSpace), .chipSelect_n(chipSelect_n),
  .plainCycle(plainCycle), .bootGlobal(bootGlobal)
);
`default_nettype wire

// ---- tb/test_chip_select_address_decode.sv ----
// Self-checking bench for the chip-select decode block.
// Assumes the package, design, checker and device model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_chip_select_address_decode
  import cs_decode_pkg::*;
;
  localparam logic [4:0] K_WR = 5'h10;
  localparam logic [4:0] K_SUP = 5'h08;
  localparam logic [4:0] K_CPU = 5'h02;
  localparam logic [4:0] K_ALT = 5'h01;
  logic ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cycleActive = 1'b0;
  logic cycleWrite = 1'b0, cycleSuper = 1'b0, cycleCode = 1'b0;
  logic cycleCpuSpace = 1'b0, cycleAltMaster = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, coreAddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, lastSel;
  logic [1:0] bresp, rresp;
  logic [7:0] chipSelect_n;
  logic awready, wready, bvalid, arready, rvalid, plainCycle, bootGlobal;
  int nFail = 0, nTests = 0;
  always #10 ref_clk = ~ref_clk;
  cs_decode uut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .coreAddr(coreAddr), .cycleActive(cycleActive),
    .cycleWrite(cycleWrite), .cycleSuper(cycleSuper), .cycleCode(cycleCode),
    .cycleCpuSpace(cycleCpuSpace), .cycleAltMaster(cycleAltMaster),
    .chipSelect_n(chipSelect_n), .plainCycle(plainCycle),
    .bootGlobal(bootGlobal));
  cs_ext_memory mem (.chipSelect_n(chipSelect_n), .ref_clk(ref_clk),
    .lastSel(lastSel));
  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d,
                    input logic [1:0] er);
    logic pa, pw, pb;
    int i;
    @(posedge ref_clk);
    {pa, pw, pb} = 3'b111;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    // Ready is combinational, so it is read mid-cycle where it has settled.
    for (i = 0; i < 40 && pb; i++) begin
      @(negedge ref_clk);
      if (bvalid === 1'b1) chk("bresp", 32'(bresp), 32'(er));
      {pa, pw, pb} = {pa && awready !== 1'b1, pw && wready !== 1'b1,
                      pb && bvalid !== 1'b1};
      @(posedge ref_clk);
      {awvalid, wvalid, bready} <= {pa, pw, pb};
    end
    if (pb) chk("write response", 32'h0, 32'h1);
    if (pb) finish_test();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    logic pr, pd;
    int i;
    @(posedge ref_clk);
    {pr, pd} = 2'b11;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (i = 0; i < 40 && pd; i++) begin
      @(negedge ref_clk);
      if (rvalid === 1'b1) chk("rdata", rdata, exp);
      if (rvalid === 1'b1) chk("rresp", 32'(rresp), 32'(er));
      {pr, pd} = {pr && arready !== 1'b1, pd && rvalid !== 1'b1};
      @(posedge ref_clk);
      {arvalid, rready} <= {pr, pd};
    end
    if (pd) chk("read response", 32'h0, 32'h1);
    if (pd) finish_test();
  endtask
  // The decode registers its answer on the edge after the cycle inputs are driven.
  task automatic cyc(input logic [31:0] a, input logic [4:0] k,
                     input logic [7:0] ecs);
    @(posedge ref_clk);
    coreAddr <= a;
    {cycleWrite, cycleSuper, cycleCode, cycleCpuSpace, cycleAltMaster} <= k;
    cycleActive <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("chipSelect_n", 32'(chipSelect_n), 32'(ecs));
    chk("plainCycle", 32'(plainCycle), 32'(ecs == CS_IDLE));
    @(posedge ref_clk);
    cycleActive <= 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  logic [9:0] quals [2:7] = '{IDX_BANK2_QUAL, IDX_BANK3_QUAL, IDX_BANK4_QUAL,
                              IDX_BANK5_QUAL, IDX_BANK6_QUAL, IDX_BANK7_QUAL};
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("bootGlobal", 32'(bootGlobal), 32'h1);
    cyc(32'h1234_5678, K_WR, 8'hFE);
    wr(IDX_BANK0_BASE, 32'h0000_0000, RESP_OKAY);
    wr(IDX_BANK0_MASK, 32'h0008_0001, RESP_OKAY);
    rd({IDX_BANK0_MASK, 2'b00}, 32'h0008_0001, RESP_OKAY);
    chk("bootGlobal", 32'(bootGlobal), 32'h0);
    cyc(32'h0008_FFFC, 5'h00, 8'hFE);
    cyc(32'h0001_0000, 5'h00, 8'hFF);
    wr(IDX_BANK1_BASE, 32'hFFFF_0020, RESP_OKAY);
    rd({IDX_BANK1_BASE, 2'b00}, 32'h0000_0020, RESP_OKAY);
    wr(IDX_BANK1_MASK, 32'h0000_0001, RESP_OKAY);
    cyc(32'h0020_FFFF, 5'h00, 8'hFD);
    cyc(32'h0021_0000, 5'h00, 8'hFF);
    wr(IDX_SHARED_BASE, 32'hFFFF_FFF0, RESP_OKAY);
    rd({IDX_SHARED_BASE, 2'b00}, 32'h0000_00F0, RESP_OKAY);
    for (int n = 2; n < 8; n++) begin
      wr(quals[n], 32'h0000_0001, RESP_OKAY);
      cyc(32'hF000_0000 | (n << 21), 5'h00, 8'hFF ^ (8'h01 << n));
    end
    // The model records on the edge that ends the cycle; let it settle.
    @(negedge ref_clk);
    chk("lastSel", 32'(lastSel), 32'h7);
    cyc(32'hF1E0_0000, 5'h00, 8'hFF);
    wr(IDX_BANK2_QUAL, 32'h0000_0101, RESP_OKAY);
    rd({IDX_BANK2_QUAL, 2'b00}, 32'h0000_0101, RESP_OKAY);
    cyc(32'hF040_0000, K_WR, 8'hFF);
    cyc(32'hF040_0000, 5'h00, 8'hFB);
    for (logic [2:0] b = 3'h1; b < 3'h5; b++) begin
      wr(IDX_BANK3_QUAL, 32'h1 | (32'h1 << b), RESP_OKAY);
      cyc(32'hF060_0000, {1'b0, b > 3'h2, ~b[0], 2'b00}, 8'hFF);
      cyc(32'hF060_0000, {1'b0, b < 3'h3, ~b[0], 2'b00}, 8'hF7);
      cyc(32'hF060_0000, {1'b0, b > 3'h2, ~b[0], 2'b01}, 8'hF7);
    end
    wr(IDX_BANK3_QUAL, 32'h0000_0041, RESP_OKAY);
    cyc(32'hF060_0000, K_ALT | K_SUP, 8'hFF);
    cyc(32'h0000_0000, K_CPU, 8'hFE);
    // A low enable must hold a select that the address has already left.
    @(posedge ref_clk);
    cycleActive <= 1'b1;
    @(posedge ref_clk);
    clkEn <= 1'b0;
    coreAddr <= 32'h0001_0000;
    repeat (2) @(posedge ref_clk);
    #1 chk("frozen select", 32'(chipSelect_n), 32'h0000_00FE);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    @(posedge ref_clk);
    #1 chk("released select", 32'(chipSelect_n), 32'h0000_00FF);
    @(posedge ref_clk);
    cycleActive <= 1'b0;
    wr(IDX_SHARED_BASE, 32'h0000_00FF, RESP_OKAY);
    cyc(32'hFFE0_0000, K_CPU, 8'h7F);
    cyc(32'hFF80_0000, K_CPU, 8'hFF);
    wr(IDX_BANK7_QUAL, 32'h0000_0021, RESP_OKAY);
    cyc(32'hFFE0_0000, K_CPU, 8'hFF);
    // Upper address byte at zero: banks 0 and 1 take slots 0 and 1.
    wr(IDX_SHARED_BASE, 32'h0000_0000, RESP_OKAY);
    wr(IDX_BANK0_MASK, 32'h001F_0001, RESP_OKAY);
    wr(IDX_BANK1_MASK, 32'h001F_0001, RESP_OKAY);
    cyc(32'h001F_FFFF, 5'h00, 8'hFE);
    cyc(32'h0020_0000, 5'h00, 8'hFD);
    cyc(32'h0040_0000, 5'h00, 8'hFB);
    rd(12'h004, 32'h0, RESP_SLVERR);
    wr(10'h001, 32'h1, RESP_SLVERR);
    finish_test();
  end
endmodule // test_chip_select_address_decode
`default_nettype wire
